// *** src/rps_pkg.sv ***
`default_nettype none
package rps_pkg;
	// Clock rate in kHz
	localparam int unsigned CLK_KHZ = 20000;
	// Power-on interval, in microseconds: least 2500, longest 10000
	localparam int unsigned POR_MIN_US = 2500;
	localparam int unsigned POR_MAX_US = 10000;
	localparam int unsigned POR_CYC = (POR_MIN_US * CLK_KHZ + 999) / 1000;
	// Watchdog least delays in milliseconds for selects 00, 01, 10, 11
	localparam int unsigned WD_MS_0 = 5;
	localparam int unsigned WD_MS_1 = 10;
	localparam int unsigned WD_MS_2 = 20;
	localparam int unsigned WD_MS_3 = 80;
	localparam int unsigned WD_CYC_0 = WD_MS_0 * CLK_KHZ;
	localparam int unsigned WD_CYC_1 = WD_MS_1 * CLK_KHZ;
	localparam int unsigned WD_CYC_2 = WD_MS_2 * CLK_KHZ;
	localparam int unsigned WD_CYC_3 = WD_MS_3 * CLK_KHZ;
	// Counter width covering the longest count
	localparam int unsigned CNT_W = 24;
	// Watchdog select encodings
	localparam logic [1:0] WD_SEL_5MS = 2'h0;
	localparam logic [1:0] WD_SEL_10MS = 2'h1;
	localparam logic [1:0] WD_SEL_20MS = 2'h2;
	localparam logic [1:0] WD_SEL_80MS = 2'h3;

	// Sequencer states
	typedef enum logic [1:0] {
		RPS_RUN = 2'b00,
		RPS_DRIVE = 2'b01,
		RPS_WAIT = 2'b10
	} rps_state_t;
endpackage : rps_pkg
`default_nettype wire

// *** src/rps_sync.sv ***
`default_nettype none
// Three-stage input synchroniser; a change counts once stages two and three agree
module rps_sync
	import rps_pkg::*;
#(
	parameter logic INIT = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Raw and filtered level
	input wire logic din,
	output logic dout
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// Shift chain; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Output follows only when the last two stages agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dout <= INIT;
		end else if (s2_q == s3_q) begin
			dout <= s3_q;
		end
	end
endmodule : rps_sync
`default_nettype wire

// *** src/rps_seq.sv ***
`default_nettype none
//Behaviour
// [RQ1] Reset on power-on, watchdog, stop recovery, low voltage or low reset pin.
// [RQ2] Power-on or watchdog reset drives pin low for the power-on interval.
// [RQ3] Internal pull-up on reset pin, switched off while the device drives low.
// [RQ4] Never drive the reset pin low while supply is below brown-out threshold.
// [RQ5] External drivers on the reset line must be open-drain only.
// [RQ6] External reset pulse does not end stop state; only recovery sources do.
// [RQ7] Two select bits choose watchdog delay 5, 10, 20 or 80 ms minimum.
// [RQ8] Internal reset held while the reset pin reads low, whoever drives it. The code ignores the low pin while stop is active.
module rps_seq
	import rps_pkg::*;
#(
	parameter int unsigned POR_CYCLES = POR_CYC,
	parameter int unsigned WD_CYCLES_0 = WD_CYC_0,
	parameter int unsigned WD_CYCLES_1 = WD_CYC_1,
	parameter int unsigned WD_CYCLES_2 = WD_CYC_2,
	parameter int unsigned WD_CYCLES_3 = WD_CYC_3
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Reset causes
	input wire logic POWER_ON,
	input wire logic LOW_VOLTAGE,
	input wire logic BROWN_OUT,
	input wire logic STOP_RECOVERY,
	// Watchdog control
	input wire logic WD_ENABLE,
	input wire logic WD_REFRESH,
	input wire logic [1:0] WD_SELECT,
	// Stop state
	input wire logic STOP_ENTER,
	output logic STOP_ACTIVE,
	// Reset pin, open-drain
	input wire logic RESET_PIN_I,
	output logic RESET_PIN_O,
	output logic RESET_PIN_OE,
	output logic RESET_PULLUP_EN,
	// Reset outputs
	output logic CORE_RESET,
	output logic WD_TIMEOUT
);
	// ****************************************
	// Checks and declarations
	// ****************************************
	// Refuse counts that the counter cannot hold
	if (POR_CYCLES < 1 || POR_CYCLES >= (1 << CNT_W) ||
		WD_CYCLES_3 >= (1 << CNT_W) || WD_CYCLES_0 < 1) begin : g_bad_counts
		$error("rps_seq: counts do not fit the counter");
	end

	rps_state_t state_q;
	rps_state_t state_d;
	logic [CNT_W-1:0] por_cnt_q;
	logic [CNT_W-1:0] wd_cnt_q;
	logic pin_low;
	logic pin_sync;
	logic por_req;
	logic wd_hit;
	logic low_v_sync;
	logic bo_sync;
	logic srec_sync;
	logic pon_sync;

	// Watchdog limit from the select bits
	function automatic logic [CNT_W-1:0] wd_limit(input logic [1:0] sel);
		case (sel)
			WD_SEL_5MS: wd_limit = CNT_W'(WD_CYCLES_0);
			WD_SEL_10MS: wd_limit = CNT_W'(WD_CYCLES_1);
			WD_SEL_20MS: wd_limit = CNT_W'(WD_CYCLES_2);
			WD_SEL_80MS: wd_limit = CNT_W'(WD_CYCLES_3);
			default: wd_limit = CNT_W'(WD_CYCLES_3);
		endcase
	endfunction

	// ****************************************
	// Pin and analog-flag synchronisers
	// ****************************************
	rps_sync #(.INIT(1'b0)) u_pin (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.din(~RESET_PIN_I),
		.dout(pin_low)
	);
	rps_sync #(.INIT(1'b0)) u_lv (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.din(LOW_VOLTAGE),
		.dout(low_v_sync)
	);
	rps_sync #(.INIT(1'b0)) u_bo (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.din(BROWN_OUT),
		.dout(bo_sync)
	);
	rps_sync #(.INIT(1'b0)) u_sr (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.din(STOP_RECOVERY),
		.dout(srec_sync)
	);
	rps_sync #(.INIT(1'b1)) u_po (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.din(POWER_ON),
		.dout(pon_sync)
	);
	assign pin_sync = pin_low;

	// ****************************************
	// Watchdog counter
	// ****************************************
	assign wd_hit = WD_ENABLE && (wd_cnt_q >= wd_limit(WD_SELECT) - CNT_W'(1)); // RQ7

	// Counts while enabled; refresh or any reset restarts it
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			wd_cnt_q <= '0;
		end else if (!WD_ENABLE || WD_REFRESH || CORE_RESET || wd_hit) begin
			wd_cnt_q <= '0;
		end else begin
			wd_cnt_q <= wd_cnt_q + CNT_W'(1); // RQ7
		end
	end

	// One-cycle time-out pulse
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			WD_TIMEOUT <= 1'b0;
		end else begin
			WD_TIMEOUT <= wd_hit && !CORE_RESET;
		end
	end

	// ****************************************
	// Drive sequencer
	// ****************************************
	assign por_req = pon_sync || WD_TIMEOUT; // RQ2

	// Next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			RPS_RUN: begin
				if (por_req && !bo_sync) begin
					state_d = RPS_DRIVE; // RQ2 RQ4
				end
			end
			RPS_DRIVE: begin
				if (bo_sync) begin
					state_d = RPS_WAIT; // RQ4
				end else if (por_cnt_q >= CNT_W'(POR_CYCLES - 1)) begin
					state_d = RPS_WAIT; // RQ2
				end
			end
			RPS_WAIT: begin
				if (!pon_sync) begin
					state_d = RPS_RUN;
				end
			end
			default: state_d = RPS_RUN;
		endcase
	end

	// State register; reset idles and the held power-on flag starts a full-length drive
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			state_q <= RPS_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// Interval counter runs only while driving
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			por_cnt_q <= '0;
		end else if (state_q == RPS_DRIVE) begin
			por_cnt_q <= por_cnt_q + CNT_W'(1); // RQ2
		end else begin
			por_cnt_q <= '0;
		end
	end

	// Pin drive: open-drain low, never under brown-out
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			RESET_PIN_OE <= 1'b0;
			RESET_PULLUP_EN <= 1'b1;
		end else begin
			RESET_PIN_OE <= (state_d == RPS_DRIVE) && !bo_sync; // RQ2 RQ4 RQ5
			RESET_PULLUP_EN <= !((state_d == RPS_DRIVE) && !bo_sync); // RQ3
		end
	end
	assign RESET_PIN_O = 1'b0; // RQ5

	// ****************************************
	// Stop state and core reset
	// ****************************************
	// Only recovery sources end stop; the pin is ignored here
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			STOP_ACTIVE <= 1'b0;
		end else if (srec_sync || pon_sync) begin
			STOP_ACTIVE <= 1'b0; // RQ6
		end else if (STOP_ENTER && !CORE_RESET) begin
			STOP_ACTIVE <= 1'b1;
		end
	end

	// Core reset from every cause; pin low holds it only while stop is not active
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			CORE_RESET <= 1'b1;
		end else begin
			CORE_RESET <= pon_sync || low_v_sync || (STOP_ACTIVE && srec_sync) ||
				(state_q == RPS_DRIVE) || WD_TIMEOUT ||
				(pin_sync && !STOP_ACTIVE); // RQ1 RQ6 RQ8
		end
	end
endmodule : rps_seq
`default_nettype wire

// *** bench/rps_seq_props.sv ***
`default_nettype none
// Port-level checks of the reset sequencer
module rps_seq_props #(
	parameter int unsigned POR_CYCLES = 20
) (
	// Clock, reset, causes
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic POWER_ON,
	input wire logic BROWN_OUT,
	input wire logic STOP_RECOVERY,
	// Pin and outputs
	input wire logic RESET_PIN_I,
	input wire logic RESET_PIN_O,
	input wire logic RESET_PIN_OE,
	input wire logic RESET_PULLUP_EN,
	input wire logic STOP_ACTIVE,
	input wire logic CORE_RESET,
	input wire logic WD_TIMEOUT
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned len_q;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);
	// Cycles the pin has been driven low
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || !RESET_PIN_OE)
			len_q <= 0;
		else
			len_q <= len_q + 1;
	end
	sequence s_wd_hit;
		WD_TIMEOUT ##1 RESET_PIN_OE;
	endsequence
	a_pull_inv: assert property (RESET_PULLUP_EN != RESET_PIN_OE && !RESET_PIN_O)
		else $error("pull-up and drive overlap");
	a_bo_quiet: assert property (BROWN_OUT [*6] |-> !RESET_PIN_OE)
		else $error("pin driven under brown-out");
	a_por_len: assert property ($fell(RESET_PIN_OE) && !BROWN_OUT |-> len_q == POR_CYCLES)
		else $error("drive length wrong");
	a_wd_pulse: assert property (WD_TIMEOUT |=> !WD_TIMEOUT)
		else $error("timeout pulse too long");
	a_wd_drive: assert property (WD_TIMEOUT |-> s_wd_hit)
		else $error("no drive after timeout");
	a_po_drive: assert property ($rose(POWER_ON) && !BROWN_OUT |-> ##[1:8] RESET_PIN_OE)
		else $error("no drive after power-on");
	a_stop_end: assert property ($fell(STOP_ACTIVE) |-> $past(STOP_RECOVERY, 3))
		else $error("stop left without recovery");
	a_pin_core: assert property ((!RESET_PIN_I && !STOP_ACTIVE) [*6] |-> CORE_RESET)
		else $error("low pin without core reset");
endmodule // rps_seq_props
`default_nettype wire

// *** bench/rps_ext_line.sv ***
`default_nettype none
// Board side of the shared reset line
module rps_ext_line (
	// Device side
	input wire logic dev_oe,
	input wire logic dev_o,
	input wire logic pull_en,
	// Board request and line level
	input wire logic ext_low,
	output logic line
);
	timeunit 1ns;
	timeprecision 1ns;
	// Wired-AND; the board only ever pulls low
	always_comb begin
		if ((dev_oe && !dev_o) || ext_low)
			line = 1'b0;
		else
			line = pull_en;
	end
endmodule // rps_ext_line
`default_nettype wire

// *** bench/rps_seq_tb.sv ***
`default_nettype none
module rps_seq_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned PC = 20;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic po = 1'b0, lv = 1'b0, bo = 1'b0, sr = 1'b0, wen = 1'b0, sen = 1'b0, ext = 1'b0;
	logic [1:0] sel = 2'h0;
	logic rfr = 1'b0;
	logic pin, p_o, oe, pu, stp, cr, wt;
	int fail_count = 0;
	int cmp_count = 0;
	int n;
	wire logic [3:0] mon = {cr, stp, wt, oe};
	// Clock
	always #25 clk = ~clk;
	rps_ext_line i_line (.dev_oe(oe), .dev_o(p_o), .pull_en(pu), .ext_low(ext), .line(pin));
	rps_seq #(.POR_CYCLES(PC), .WD_CYCLES_0(30), .WD_CYCLES_1(40), .WD_CYCLES_2(50),
		.WD_CYCLES_3(60)) i_dut (.CLK_SYS(clk), .RST_N(rst_n), .POWER_ON(po),
		.LOW_VOLTAGE(lv), .BROWN_OUT(bo), .STOP_RECOVERY(sr), .WD_ENABLE(wen),
		.WD_REFRESH(rfr), .WD_SELECT(sel), .STOP_ENTER(sen), .STOP_ACTIVE(stp),
		.RESET_PIN_I(pin), .RESET_PIN_O(p_o), .RESET_PIN_OE(oe), .RESET_PULLUP_EN(pu),
		.CORE_RESET(cr), .WD_TIMEOUT(wt));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s exp %0h got %0h", nm, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Bounded wait for an output level, edges counted in n; looks off the edge, when settled
	task automatic wait_for(input int k, input logic v);
		#1;
		for (n = 0; mon[k] !== v; n++) begin
			if (n == 400) begin
				fail_count++;
				report_and_stop();
			end
			@(posedge clk);
			#1;
		end
	endtask
	// One drive period, pull-up off at its start
	task automatic drive_len();
		wait_for(0, 1);
		chk("pull", 0, pu);
		wait_for(0, 0);
		chk("len", PC, n);
		wait_for(3, 0);
	endtask
	task automatic t_por();
		drive_len();
		@(posedge clk) po <= 1'b1;
		repeat (4) @(posedge clk);
		po <= 1'b0;
		drive_len();
	endtask
	task automatic t_wd();
		for (int s = 0; s < 4; s++) begin
			@(posedge clk) sel <= s[1:0];
			wen <= 1'b1;
			wait_for(1, 1);
			chk("wd", 1, n >= 30 + 10 * s && n <= 33 + 10 * s);
			@(posedge clk) wen <= 1'b0;
			drive_len();
		end
	endtask
	// Refresh restarts the count, so the time-out comes a full delay after it
	task automatic t_refresh();
		@(posedge clk) sel <= 2'h0;
		wen <= 1'b1;
		repeat (20) @(posedge clk);
		rfr <= 1'b1;
		@(posedge clk) rfr <= 1'b0;
		wait_for(1, 1);
		chk("refresh", 1, n >= 29 && n <= 31);
		@(posedge clk) wen <= 1'b0;
		drive_len();
	endtask
	task automatic t_ext();
		@(posedge clk) ext <= 1'b1;
		repeat (8) @(posedge clk);
		#1;
		chk("ext core", 1, cr);
		chk("ext oe", 0, oe);
		@(posedge clk) ext <= 1'b0;
		wait_for(3, 0);
		@(posedge clk) lv <= 1'b1;
		wait_for(3, 1);
		@(posedge clk) lv <= 1'b0;
		wait_for(3, 0);
	endtask
	task automatic t_stop();
		@(posedge clk) sen <= 1'b1;
		@(posedge clk) sen <= 1'b0;
		wait_for(2, 1);
		@(posedge clk) ext <= 1'b1;
		repeat (10) @(posedge clk);
		#1;
		chk("stop kept", 1, stp);
		chk("stop core", 0, cr);
		@(posedge clk) ext <= 1'b0;
		repeat (6) @(posedge clk);
		sr <= 1'b1;
		wait_for(3, 1);
		wait_for(2, 0);
		@(posedge clk) sr <= 1'b0;
		wait_for(3, 0);
	endtask
	task automatic t_bo();
		@(posedge clk) bo <= 1'b1;
		repeat (6) @(posedge clk);
		po <= 1'b1;
		repeat (20) begin
			@(posedge clk);
			#1;
			chk("bo oe", 0, oe);
		end
		@(posedge clk) rst_n <= 1'b0;
		po <= 1'b0;
		bo <= 1'b0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		drive_len();
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_por();
		t_wd();
		t_refresh();
		t_ext();
		t_stop();
		t_bo();
		report_and_stop();
	end
endmodule // rps_seq_tb
bind rps_seq rps_seq_props #(.POR_CYCLES(POR_CYCLES)) i_props (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
	.POWER_ON(POWER_ON), .BROWN_OUT(BROWN_OUT), .STOP_RECOVERY(STOP_RECOVERY),
	.RESET_PIN_I(RESET_PIN_I), .RESET_PIN_O(RESET_PIN_O), .RESET_PIN_OE(RESET_PIN_OE),
	.RESET_PULLUP_EN(RESET_PULLUP_EN), .STOP_ACTIVE(STOP_ACTIVE), .CORE_RESET(CORE_RESET),
	.WD_TIMEOUT(WD_TIMEOUT));
`default_nettype wire
